// File: hw/tco_pkg.sv
// Constants shared by the 16-bit timer compare-output block and its register map.
// Behaviour
// RL1 - Route wave only with action and route bit
// RL2 - Port direction bit still controls pin drive
// RL3 - Wave state presettable before pin enabled
// RL4 - Action bits never touch capture logic
// RL5 - Action zero leaves wave state unchanged
// RL6 - New action applies at next match only
// RL7 - Force strobe applies action at once
// RL8 - Only mode bits shape counting sequence
// RL9 - Action bits select set, clear, toggle
// RL10 - Route bit decides per pin over action
// RL11 - Mode zero counts up, wraps to zero
// RL12 - Overflow flag set when count becomes zero
// RL13 - Hardware only sets overflow; service clears it
// RL14 - Count writable any time in normal mode
// RL15 - Clear-on-match uses compare A or capture
// RL16 - Top match raises compare A or capture flag
// RL17 - Top not buffered; low top forces wrap
// RL18 - Action one toggles channel A each match
// RL19 - Toggle rate is clock over 2N(1+top)
// RL20 - Overflow flag on max to zero passage
// RL21 - Compare flag set on following timer tick
// RL22 - Reset clears wave state registers to zero
// RL23 - Force sets no flag, leaves counter alone
// RL24 - Wave state changes on timer tick only; a force strobe changes it on any pclk edge without a tick
package tco_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ROUTE = 8'h04;
	localparam logic [7:0] OFF_FORCE = 8'h08;
	localparam logic [7:0] OFF_COUNT = 8'h0C;
	localparam logic [7:0] OFF_CMPA = 8'h10;
	localparam logic [7:0] OFF_CMPB = 8'h14;
	localparam logic [7:0] OFF_CAPT = 8'h18;
	localparam logic [7:0] OFF_FLAGS = 8'h1C;
	localparam logic [7:0] OFF_WAVE = 8'h20;

	// ==========================================================
	// Field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_ACTA_LSB = 4;
	localparam int CTRL_ACTB_LSB = 6;
	localparam int ROUTE_B_LSB = 4;
	localparam int FORCE_A_BIT = 0;
	localparam int FORCE_B_BIT = 1;
	localparam int FLAG_OVF_BIT = 0;
	localparam int FLAG_CMPA_BIT = 1;
	localparam int FLAG_CMPB_BIT = 2;
	localparam int FLAG_CAPT_BIT = 3;
	localparam int WAVE_A_BIT = 0;
	localparam int WAVE_B_BIT = 1;
	localparam int MAX_PINS = 4;

	// ==========================================================
	// Modes, actions, counter extremes, reset values
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
	localparam logic [3:0] MODE_CTC_CAPT = 4'hC;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] CNT_BOTTOM = 16'h0000;
	localparam logic [15:0] CNT_STEP = 16'h0001;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [7:0] RST_ROUTE = 8'h00;
	localparam logic RST_WAVE = 1'b0;

endpackage

// File: hw/tco_timer16.sv
// Top module: 16-bit timer with normal and clear-on-match modes and compare-output pin routing.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module tco_timer16 #(
	parameter int PINS = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tco_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timer_tick,
	input wire logic [3:0] flag_service,
	input wire logic [PINS-1:0] port_out_a,
	input wire logic [PINS-1:0] port_out_b,
	input wire logic [PINS-1:0] compare_pin_direction_a,
	input wire logic [PINS-1:0] compare_pin_direction_b,
	output logic [PINS-1:0] compare_wave_pin_a,
	output logic [PINS-1:0] compare_wave_pin_b,
	output logic [PINS-1:0] compare_wave_pin_oe_a,
	output logic [PINS-1:0] compare_wave_pin_oe_b
);

	// ==========================================================
	// Parameter check
	generate
		if (PINS < 1 || PINS > tco_pkg::MAX_PINS) begin : g_bad_pins
			$error("PINS must be between 1 and 4");
		end
	endgenerate

	// ==========================================================
	// State
	typedef struct packed {
		logic [3:0] waveform_mode_select;
		logic [1:0] act_a;
		logic [1:0] act_b;
		logic [7:0] pin_route_control_reg;
		logic [15:0] count_value;
		logic [15:0] compare_a_value;
		logic [15:0] compare_b_value;
		logic [15:0] capture_value;
		logic overflow_flag;
		logic compare_a_flag;
		logic compare_b_flag;
		logic capture_flag;
		logic wave_a;
		logic wave_b;
		logic block;
		logic [31:0] rdata;
		logic slverr;
		logic [PINS-1:0] pin_a;
		logic [PINS-1:0] pin_b;
		logic [PINS-1:0] oe_a;
		logic [PINS-1:0] oe_b;
	} tco_state_t;

	tco_state_t r;
	tco_state_t next_r;

	// ==========================================================
	// Decoders as functions; tco_apply is used in more than one place
	function automatic logic tco_apply(input logic [1:0] act, input logic cur);
		logic res;
		res = cur;
		unique case (act)
			tco_pkg::ACT_NONE: res = cur;
			tco_pkg::ACT_TOGGLE: res = ~cur;
			tco_pkg::ACT_CLEAR: res = 1'b0;
			tco_pkg::ACT_SET: res = 1'b1;
		endcase
		return res;
	endfunction

	function automatic logic tco_non_pwm(input logic [3:0] mode);
		return (mode == tco_pkg::MODE_NORMAL) || (mode == tco_pkg::MODE_CTC_CMPA) ||
			(mode == tco_pkg::MODE_CTC_CAPT);
	endfunction

	// ==========================================================
	// Decoded events
	logic acc_wr;
	logic wr_count;
	logic wr_force;
	logic is_ctc;
	logic non_pwm;
	logic [15:0] top_value;
	logic match_a;
	logic match_b;
	logic top_match;
	logic force_a;
	logic force_b;

	assign acc_wr = psel & penable & pwrite;
	assign wr_count = acc_wr && (paddr == tco_pkg::OFF_COUNT);
	assign wr_force = acc_wr && (paddr == tco_pkg::OFF_FORCE);
	assign non_pwm = tco_non_pwm(r.waveform_mode_select);
	assign is_ctc = (r.waveform_mode_select == tco_pkg::MODE_CTC_CMPA) ||
		(r.waveform_mode_select == tco_pkg::MODE_CTC_CAPT);
	// Top source chosen by mode alone; capture logic never sees action bits [RL4] [RL15]
	assign top_value = (r.waveform_mode_select == tco_pkg::MODE_CTC_CAPT) ?
		r.capture_value : r.compare_a_value;
	// A count write blocks matches for the next tick
	assign match_a = (r.count_value == r.compare_a_value) & ~r.block;
	assign match_b = (r.count_value == r.compare_b_value) & ~r.block;
	assign top_match = is_ctc & (r.count_value == top_value) & ~r.block; // [RL17]
	assign force_a = wr_force & pwdata[tco_pkg::FORCE_A_BIT] & non_pwm;
	assign force_b = wr_force & pwdata[tco_pkg::FORCE_B_BIT] & non_pwm;

	// ==========================================================
	// Next state
	always_comb begin
		next_r = r;

		// APB read data and error latched in setup, shown in access
		if (psel && !penable) begin
			next_r.slverr = 1'b0;
			next_r.rdata = 32'h00000000;
			case (paddr)
				tco_pkg::OFF_CTRL: begin
					next_r.rdata[tco_pkg::CTRL_MODE_LSB +: 4] = r.waveform_mode_select;
					next_r.rdata[tco_pkg::CTRL_ACTA_LSB +: 2] = r.act_a;
					next_r.rdata[tco_pkg::CTRL_ACTB_LSB +: 2] = r.act_b;
				end
				tco_pkg::OFF_ROUTE: next_r.rdata[7:0] = r.pin_route_control_reg;
				tco_pkg::OFF_FORCE: next_r.rdata = 32'h00000000;
				tco_pkg::OFF_COUNT: next_r.rdata[15:0] = r.count_value;
				tco_pkg::OFF_CMPA: next_r.rdata[15:0] = r.compare_a_value;
				tco_pkg::OFF_CMPB: next_r.rdata[15:0] = r.compare_b_value;
				tco_pkg::OFF_CAPT: next_r.rdata[15:0] = r.capture_value;
				tco_pkg::OFF_FLAGS: begin
					next_r.rdata[tco_pkg::FLAG_OVF_BIT] = r.overflow_flag;
					next_r.rdata[tco_pkg::FLAG_CMPA_BIT] = r.compare_a_flag;
					next_r.rdata[tco_pkg::FLAG_CMPB_BIT] = r.compare_b_flag;
					next_r.rdata[tco_pkg::FLAG_CAPT_BIT] = r.capture_flag;
				end
				tco_pkg::OFF_WAVE: begin
					next_r.rdata[tco_pkg::WAVE_A_BIT] = r.wave_a;
					next_r.rdata[tco_pkg::WAVE_B_BIT] = r.wave_b;
				end
				default: next_r.slverr = 1'b1;
			endcase
		end

		// Clears first so that a set in the same cycle wins [RL13]
		if (acc_wr && paddr == tco_pkg::OFF_FLAGS) begin
			if (pwdata[tco_pkg::FLAG_OVF_BIT]) next_r.overflow_flag = 1'b0;
			if (pwdata[tco_pkg::FLAG_CMPA_BIT]) next_r.compare_a_flag = 1'b0;
			if (pwdata[tco_pkg::FLAG_CMPB_BIT]) next_r.compare_b_flag = 1'b0;
			if (pwdata[tco_pkg::FLAG_CAPT_BIT]) next_r.capture_flag = 1'b0;
		end
		if (flag_service[tco_pkg::FLAG_OVF_BIT]) next_r.overflow_flag = 1'b0; // [RL13]
		if (flag_service[tco_pkg::FLAG_CMPA_BIT]) next_r.compare_a_flag = 1'b0;
		if (flag_service[tco_pkg::FLAG_CMPB_BIT]) next_r.compare_b_flag = 1'b0;
		if (flag_service[tco_pkg::FLAG_CAPT_BIT]) next_r.capture_flag = 1'b0;

		// Counter and compare logic advance only on timer ticks [RL24]
		if (timer_tick) begin
			next_r.block = 1'b0;
			// Overflow on MAX to BOTTOM, the same tick the count becomes zero [RL12] [RL20]
			if (r.count_value == tco_pkg::CNT_MAX) begin
				next_r.overflow_flag = 1'b1;
			end
			// Sequence depends on mode only; normal mode never clears [RL8] [RL11] [RL15]
			// A period of top+1 ticks per toggle sets the output rate [RL19]
			if (top_match) begin
				next_r.count_value = tco_pkg::CNT_BOTTOM;
			end else begin
				next_r.count_value = r.count_value + tco_pkg::CNT_STEP;
			end
			// Flags rise on the tick after the count reached the compare value [RL21] [RL16]
			if (match_a) begin
				next_r.compare_a_flag = 1'b1;
			end
			if (match_b) begin
				next_r.compare_b_flag = 1'b1;
			end
			if (top_match && r.waveform_mode_select == tco_pkg::MODE_CTC_CAPT) begin
				next_r.capture_flag = 1'b1; // [RL16]
			end
			// Action read live at match time; zero holds, one toggles [RL5] [RL6] [RL9] [RL18]
			if (match_a && non_pwm) begin
				next_r.wave_a = tco_apply(r.act_a, r.wave_a);
			end
			if (match_b && non_pwm) begin
				next_r.wave_b = tco_apply(r.act_b, r.wave_b);
			end
		end

		// Software writes
		if (acc_wr) begin
			case (paddr)
				tco_pkg::OFF_CTRL: begin
					next_r.waveform_mode_select = pwdata[tco_pkg::CTRL_MODE_LSB +: 4];
					next_r.act_a = pwdata[tco_pkg::CTRL_ACTA_LSB +: 2]; // [RL6]
					next_r.act_b = pwdata[tco_pkg::CTRL_ACTB_LSB +: 2];
				end
				tco_pkg::OFF_ROUTE: next_r.pin_route_control_reg = pwdata[7:0];
				tco_pkg::OFF_CMPA: next_r.compare_a_value = pwdata[15:0];
				tco_pkg::OFF_CMPB: next_r.compare_b_value = pwdata[15:0];
				// Top is used unbuffered; a top below the count runs on to a wrap [RL17]
				tco_pkg::OFF_CAPT: next_r.capture_value = pwdata[15:0];
				default: begin
				end
			endcase
		end
		// Count write wins over the tick and is accepted at any time [RL14]
		if (wr_count) begin
			next_r.count_value = pwdata[15:0];
			next_r.block = 1'b1;
		end
		// Force acts on the system clock, after any match, with no flag or count change
		if (force_a) begin
			next_r.wave_a = tco_apply(r.act_a, next_r.wave_a); // [RL7] [RL23] [RL3]
		end
		if (force_b) begin
			next_r.wave_b = tco_apply(r.act_b, next_r.wave_b); // [RL7] [RL23] [RL3]
		end

		// Pin override per pin; direction always from the port [RL1] [RL10] [RL2]
		for (int i = 0; i < PINS; i++) begin
			next_r.pin_a[i] = (r.act_a != tco_pkg::ACT_NONE && r.pin_route_control_reg[i]) ?
				r.wave_a : port_out_a[i];
			next_r.pin_b[i] = (r.act_b != tco_pkg::ACT_NONE &&
				r.pin_route_control_reg[tco_pkg::ROUTE_B_LSB + i]) ? r.wave_b : port_out_b[i];
			next_r.oe_a[i] = compare_pin_direction_a[i];
			next_r.oe_b[i] = compare_pin_direction_b[i];
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r.waveform_mode_select <= tco_pkg::MODE_NORMAL;
			r.act_a <= tco_pkg::ACT_NONE;
			r.act_b <= tco_pkg::ACT_NONE;
			r.pin_route_control_reg <= tco_pkg::RST_ROUTE;
			r.count_value <= tco_pkg::RST_WORD;
			r.compare_a_value <= tco_pkg::RST_WORD;
			r.compare_b_value <= tco_pkg::RST_WORD;
			r.capture_value <= tco_pkg::RST_WORD;
			r.overflow_flag <= 1'b0;
			r.compare_a_flag <= 1'b0;
			r.compare_b_flag <= 1'b0;
			r.capture_flag <= 1'b0;
			r.wave_a <= tco_pkg::RST_WAVE; // [RL22]
			r.wave_b <= tco_pkg::RST_WAVE; // [RL22]
			r.block <= 1'b0;
			r.rdata <= 32'h00000000;
			r.slverr <= 1'b0;
			r.pin_a <= '0;
			r.pin_b <= '0;
			r.oe_a <= '0;
			r.oe_b <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign prdata = r.rdata;
	assign pready = 1'b1;
	assign pslverr = r.slverr & psel & penable;
	assign compare_wave_pin_a = r.pin_a;
	assign compare_wave_pin_b = r.pin_b;
	assign compare_wave_pin_oe_a = r.oe_a;
	assign compare_wave_pin_oe_b = r.oe_b;

	// ==========================================================
	// Assertions
	logic plain_tick;
	assign plain_tick = timer_tick & ~wr_count & ~wr_force;

	generate
		for (genvar g = 0; g < PINS; g++) begin : g_pin_chk
			property p_route_on;
				@(posedge pclk) disable iff (!presetn)
				(r.act_a != tco_pkg::ACT_NONE && r.pin_route_control_reg[g])
					|=> compare_wave_pin_a[g] == $past(r.wave_a);
			endproperty
			a_route_on: assert property (p_route_on) else $error("pin A not on wave"); // [RL1]

			property p_route_off;
				@(posedge pclk) disable iff (!presetn)
				(r.act_a == tco_pkg::ACT_NONE || !r.pin_route_control_reg[g])
					|=> compare_wave_pin_a[g] == $past(port_out_a[g]);
			endproperty
			a_route_off: assert property (p_route_off) else $error("pin A not port"); // [RL10]

			property p_dir;
				@(posedge pclk) disable iff (!presetn)
				1'b1 |=> compare_wave_pin_oe_b[g] == $past(compare_pin_direction_b[g]);
			endproperty
			a_dir: assert property (p_dir) else $error("pin B enable not direction"); // [RL2]
		end
	endgenerate

	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		(plain_tick && match_b && r.act_b == tco_pkg::ACT_NONE) |=> $stable(r.wave_b);
	endproperty
	a_hold: assert property (p_hold) else $error("action zero changed wave B"); // [RL5]

	property p_toggle;
		@(posedge pclk) disable iff (!presetn)
		(plain_tick && match_a && r.act_a == tco_pkg::ACT_TOGGLE && non_pwm)
			|=> r.wave_a != $past(r.wave_a);
	endproperty
	a_toggle: assert property (p_toggle) else $error("wave A did not toggle"); // [RL18]

	property p_wrap;
		@(posedge pclk) disable iff (!presetn)
		(plain_tick && r.waveform_mode_select == tco_pkg::MODE_NORMAL &&
			r.count_value == tco_pkg::CNT_MAX)
			|=> r.count_value == tco_pkg::CNT_BOTTOM && r.overflow_flag;
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap with overflow"); // [RL11]

	property p_ovf_cause;
		@(posedge pclk) disable iff (!presetn)
		$rose(r.overflow_flag) |-> $past(timer_tick) &&
			$past(r.count_value) == tco_pkg::CNT_MAX;
	endproperty
	a_ovf_cause: assert property (p_ovf_cause) else $error("overflow without max"); // [RL12]

	property p_step;
		@(posedge pclk) disable iff (!presetn)
		(plain_tick && !top_match) |=> r.count_value == $past(r.count_value) + tco_pkg::CNT_STEP;
	endproperty
	a_step: assert property (p_step) else $error("count did not step"); // [RL8]

	property p_clear;
		@(posedge pclk) disable iff (!presetn)
		(plain_tick && is_ctc && r.count_value == top_value && !r.block)
			|=> r.count_value == tco_pkg::CNT_BOTTOM;
	endproperty
	a_clear: assert property (p_clear) else $error("no clear at top"); // [RL15]

	property p_flag_next;
		@(posedge pclk) disable iff (!presetn)
		(timer_tick && match_b) |=> r.compare_b_flag;
	endproperty
	a_flag_next: assert property (p_flag_next) else $error("compare B flag late"); // [RL21]

	property p_force;
		@(posedge pclk) disable iff (!presetn)
		(force_a && !timer_tick && r.act_a == tco_pkg::ACT_SET)
			|=> r.wave_a && $stable(r.count_value) && !$rose(r.compare_a_flag);
	endproperty
	a_force: assert property (p_force) else $error("force wrong"); // [RL7]

	property p_cnt_wr;
		@(posedge pclk) disable iff (!presetn)
		wr_count |=> r.count_value == $past(pwdata[15:0]);
	endproperty
	a_cnt_wr: assert property (p_cnt_wr) else $error("count write lost"); // [RL14]

	property p_capt_flag;
		@(posedge pclk) disable iff (!presetn)
		(timer_tick && top_match && r.waveform_mode_select == tco_pkg::MODE_CTC_CAPT)
			|=> r.capture_flag;
	endproperty
	a_capt_flag: assert property (p_capt_flag) else $error("capture flag missing"); // [RL16]

	c_toggle: cover property (@(posedge pclk) disable iff (!presetn)
		plain_tick && match_a && is_ctc && r.act_a == tco_pkg::ACT_TOGGLE);
	c_ovf: cover property (@(posedge pclk) disable iff (!presetn) $rose(r.overflow_flag));
	c_force: cover property (@(posedge pclk) disable iff (!presetn) force_b);
	c_capt_top: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(r.capture_flag));

endmodule

// File: bench/tco_port_model.sv
// Port pin model: normal port values, direction bits and pad resolution.
`timescale 1ns/100ps
module tco_port_model #(
	parameter int PINS = 4
) (
	input wire logic pclk,
	input wire logic [2*PINS-1:0] want_out,
	input wire logic [2*PINS-1:0] want_dir,
	input wire logic [2*PINS-1:0] pin,
	input wire logic [2*PINS-1:0] oe,
	output logic [2*PINS-1:0] port_out,
	output logic [2*PINS-1:0] dir,
	output logic [2*PINS-1:0] pad
);
	logic [2*PINS-1:0] last = '0;
	assign port_out = want_out;
	assign dir = want_dir;
	// Undriven pads show the inverse of their last level, so a stale copy never passes
	assign pad = (oe & pin) | (~oe & ~last);
	always @(posedge pclk) begin
		last <= pad;
	end
endmodule

// File: bench/tco_timer16_tb.sv
// Self-checking bench for the 16-bit timer compare-output block.
`timescale 1ns/100ps
module tco_timer16_tb;
	typedef struct {logic [7:0] a; logic [32:0] e;} tco_note_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic timer_tick = 1'b0;
	logic [3:0] flag_service = 4'h0;
	logic [7:0] want_out = 8'h00;
	logic [7:0] want_dir = 8'h00;
	logic [7:0] port_out;
	logic [7:0] dir;
	logic [7:0] pin;
	logic [7:0] oe;
	logic [7:0] pad;
	logic pin_chk = 1'b0;
	logic [1:0] act_a = 2'h0;
	logic [1:0] act_b = 2'h0;
	logic wa = 1'b0;
	logic wb = 1'b0;
	logic [7:0] ep;
	logic [31:0] r;
	tco_note_t q[$];
	int n_errors = 0;
	int compares = 0;

	always #12.5 pclk = ~pclk;

	tco_timer16 #(.PINS(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_tick(timer_tick),
		.flag_service(flag_service), .port_out_a(port_out[3:0]),
		.port_out_b(port_out[7:4]), .compare_pin_direction_a(dir[3:0]),
		.compare_pin_direction_b(dir[7:4]), .compare_wave_pin_a(pin[3:0]),
		.compare_wave_pin_b(pin[7:4]), .compare_wave_pin_oe_a(oe[3:0]),
		.compare_wave_pin_oe_b(oe[7:4]));

	tco_port_model #(.PINS(4)) pins_u (.pclk(pclk), .want_out(want_out),
		.want_dir(want_dir), .pin(pin), .oe(oe), .port_out(port_out), .dir(dir), .pad(pad));

	// ========
	// Bus, tick and check tasks
	function automatic logic nxt(input logic [1:0] a, input logic w);
		if (a == tco_pkg::ACT_TOGGLE) return ~w;
		if (a == tco_pkg::ACT_CLEAR) return 1'b0;
		if (a == tco_pkg::ACT_SET) return 1'b1;
		return w;
	endfunction

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		q.push_back('{a, e});
		apb(1'b0, a, 32'h0);
	endtask

	task automatic ctrl(input logic [3:0] m, input logic [1:0] a, input logic [1:0] b);
		act_a = a;
		act_b = b;
		wr(tco_pkg::OFF_CTRL, {24'h0, b, a, m});
	endtask

	task automatic tk(input int n);
		repeat (n) begin
			timer_tick <= 1'b1;
			@(posedge pclk);
		end
		timer_tick <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic pchk(input logic [7:0] e);
		q.push_back('{8'hFF, {17'h0, want_dir, e & want_dir}});
		pin_chk <= 1'b1;
		@(posedge pclk);
		pin_chk <= 1'b0;
	endtask

	task automatic final_report();
		$display("Counts: %0d compares, %0d mismatches", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// ========
	// Result watcher
	always @(posedge pclk) begin : mon
		tco_note_t n;
		logic [32:0] got;
		if ((psel && penable && !pwrite) || pin_chk) begin
			n = q.pop_front();
			got = pin_chk ? {17'h0, oe, pad & oe} : {pslverr, prdata};
			compares++;
			if (got !== n.e) begin
				n_errors++;
				$display("MISMATCH %s expected %h seen %h", (n.a == 8'hFF) ? "pins" : "prdata",
					n.e, got);
			end
		end
	end

	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		$display("MISMATCH watchdog expected finish seen timeout");
		final_report();
	end

	// ========
	// Tests
	initial begin
		void'($urandom(15832));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 9; i++) rd(8'(4 * i), 33'h0);
		rd(8'h24, {1'b1, 32'h0});
		pchk(8'h00);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			ctrl(tco_pkg::MODE_NORMAL, 2'(3 - i), 2'(i));
			wr(tco_pkg::OFF_FORCE, 32'h3);
			wa = nxt(act_a, wa);
			wb = nxt(act_b, wb);
			rd(tco_pkg::OFF_WAVE, {31'h0, wb, wa});
		end
		rd(tco_pkg::OFF_FLAGS, 33'h0);
		rd(tco_pkg::OFF_COUNT, 33'h0);
		$display("test force done");
		wr(tco_pkg::OFF_COUNT, 32'hFFFE);
		tk(1);
		rd(tco_pkg::OFF_FLAGS, 33'h0);
		tk(1);
		rd(tco_pkg::OFF_COUNT, 33'h0);
		rd(tco_pkg::OFF_FLAGS, 33'h1);
		wr(tco_pkg::OFF_FLAGS, 32'h1);
		rd(tco_pkg::OFF_FLAGS, 33'h0);
		tk(1);
		wa = nxt(act_a, wa);
		wb = nxt(act_b, wb);
		rd(tco_pkg::OFF_FLAGS, 33'h6);
		rd(tco_pkg::OFF_WAVE, {31'h0, wb, wa});
		flag_service <= 4'h2;
		@(posedge pclk);
		flag_service <= 4'h0;
		rd(tco_pkg::OFF_FLAGS, 33'h4);
		$display("test normal done");
		wr(tco_pkg::OFF_FLAGS, 32'hF);
		wr(tco_pkg::OFF_CMPA, 32'h2);
		wr(tco_pkg::OFF_CMPB, 32'h1234);
		ctrl(tco_pkg::MODE_CTC_CMPA, tco_pkg::ACT_TOGGLE, tco_pkg::ACT_NONE);
		wr(tco_pkg::OFF_COUNT, 32'h0);
		repeat (2) begin
			tk(2);
			rd(tco_pkg::OFF_WAVE, {31'h0, wb, wa});
			tk(1);
			wa = ~wa;
			rd(tco_pkg::OFF_COUNT, 33'h0);
			rd(tco_pkg::OFF_WAVE, {31'h0, wb, wa});
		end
		rd(tco_pkg::OFF_FLAGS, 33'h2);
		wr(tco_pkg::OFF_FLAGS, 32'hF);
		// Count above top must run through the wrap before the next match
		wr(tco_pkg::OFF_COUNT, 32'hFFFD);
		tk(3);
		rd(tco_pkg::OFF_COUNT, 33'h0);
		rd(tco_pkg::OFF_FLAGS, 33'h1);
		wr(tco_pkg::OFF_FLAGS, 32'hF);
		wr(tco_pkg::OFF_CMPB, 32'h1);
		wr(tco_pkg::OFF_CAPT, 32'h3);
		ctrl(tco_pkg::MODE_CTC_CAPT, tco_pkg::ACT_NONE, tco_pkg::ACT_NONE);
		tk(4);
		rd(tco_pkg::OFF_COUNT, 33'h0);
		rd(tco_pkg::OFF_FLAGS, 33'hE);
		rd(tco_pkg::OFF_WAVE, {31'h0, wb, wa});
		// Force is refused outside the non-PWM modes
		ctrl(4'hF, tco_pkg::ACT_TOGGLE, tco_pkg::ACT_TOGGLE);
		wr(tco_pkg::OFF_FORCE, 32'h3);
		rd(tco_pkg::OFF_WAVE, {31'h0, wb, wa});
		$display("test clear-on-match done");
		repeat (16) begin
			r = $urandom;
			ctrl(tco_pkg::MODE_NORMAL, r[9:8], r[11:10]);
			wr(tco_pkg::OFF_ROUTE, {24'h0, r[7:0]});
			want_out <= r[19:12];
			want_dir <= r[27:20];
			repeat (3) @(posedge pclk);
			for (int j = 0; j < 4; j++) begin
				ep[j] = (r[9:8] != 2'h0 && r[j]) ? wa : r[12 + j];
				ep[4 + j] = (r[11:10] != 2'h0 && r[4 + j]) ? wb : r[16 + j];
			end
			pchk(ep);
		end
		$display("test routing done");
		repeat (2) @(posedge pclk);
		final_report();
	end
endmodule
